// file: hdl/ppchk_top.sv
// Page permission checker: per-page entries, request admit/block, fault event.
// Assumes requestors present code, privilege and type with each request;
// DMA engine latches code and privilege at start and passes them in here.
`timescale 1ns/10ps
// Behaviour
// - Memory split into pages, each with entry
// - 16-bit entry: requestor bits, access bits
// - DMA accesses carry starting requestor's code
// - DMA privilege fixed at transfer start
// - Privilege selects which access bits apply
// - Bits 10-15 admit codes 0-5
// - Bit 9 admits codes six and up
// - Local bit alone governs CPU local access
// - Code bits govern DMA and nonlocal CPU
// - Data is read/write, fetch is execute
// - Supervisor bits 5-3, user read/write 2-1
// - User execute bit 0, one permits
// - Failing access blocked, memory unchanged
// - Invalid access raises fault event
module ppchk_top #(
   parameter int PAGES = ppchk_pkg::PPCHK_PAGES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Access request and verdict
   input wire ppchk_pkg::ppchk_req_t req_i,
   output ppchk_pkg::ppchk_rsp_t rsp_o,
   // Register port
   input wire ppchk_pkg::ppchk_bus_t bus_i,
   output logic [31:0] rdata_o,
   // Fault event and interrupt
   output logic fault_o,
   output logic irq_o
);
   import ppchk_pkg::*;

   typedef struct packed {
      logic [PAGES-1:0][15:0] entry;
      logic [PPCHK_ST_W-1:0] status;
      logic [PPCHK_ST_W-1:0] mask;
      ppchk_rsp_t rsp;
      logic fault;
      logic irq;
      logic [31:0] rdata;
   } ppchk_state_t;

   ppchk_state_t st;
   ppchk_state_t next_st;
   logic [PPCHK_PAGE_W-1:0] page;
   logic [15:0] ent;
   logic code_ok;
   logic type_ok;
   logic admit;
   logic [PPCHK_REG_AW-1:0] eidx;
   logic [PPCHK_PAGE_W-1:0] widx;
   logic ewin;

   // Page lookup: one entry per page by address slice
   assign page = req_i.addr[PPCHK_PAGE_SHIFT +: PPCHK_PAGE_W];
   assign ent = st.entry[page];

   // Requestor check; local CPU accesses ignore the code bits
   always_comb begin
      code_ok = 1'b0;
      if (req_i.local_cpu) begin
         code_ok = ent[PPCHK_BIT_LOCAL];
      end else if (req_i.code >= PPCHK_CODE_W'(PPCHK_NUM_DED)) begin
         code_ok = ent[PPCHK_BIT_HIGH];
      end else begin
         code_ok = ent[PPCHK_BIT_CODE0 + int'(req_i.code)];
      end
   end

   // Type check, privilege picks the bit triplet
   always_comb begin
      type_ok = 1'b0;
      case (req_i.acc)
         PPCHK_ACC_READ:  type_ok = req_i.sup ? ent[PPCHK_BIT_SR] : ent[PPCHK_BIT_UR];
         PPCHK_ACC_WRITE: type_ok = req_i.sup ? ent[PPCHK_BIT_SW] : ent[PPCHK_BIT_UW];
         PPCHK_ACC_EXEC:  type_ok = req_i.sup ? ent[PPCHK_BIT_SX] : ent[PPCHK_BIT_UX];
         default:         type_ok = 1'b0;
      endcase
   end

   // Both checks must pass; the privilege is used as presented
   assign admit = code_ok & type_ok;

   // Register decode for the entry window
   assign eidx = bus_i.addr - PPCHK_OFS_ENTRY0;
   assign widx = eidx[2 +: PPCHK_PAGE_W];
   assign ewin = (bus_i.addr >= PPCHK_OFS_ENTRY0) && (bus_i.addr <= PPCHK_OFS_ENTRY_LAST)
                 && (int'(widx) < PAGES);

   // Next state: verdict, fault flag, registers
   always_comb begin
      next_st = st;
      next_st.rsp.grant = req_i.valid & admit;
      next_st.rsp.block = req_i.valid & ~admit;
      next_st.fault = req_i.valid & ~admit;
      next_st.rdata = 32'h0000_0000;
      if (bus_i.rd) begin
         if (bus_i.addr == PPCHK_OFS_STATUS) begin
            next_st.rdata = {{(32-PPCHK_ST_W){1'b0}}, st.status};
            next_st.status = '0;
         end else if (bus_i.addr == PPCHK_OFS_MASK) begin
            next_st.rdata = {{(32-PPCHK_ST_W){1'b0}}, st.mask};
         end else if (ewin) begin
            next_st.rdata = {16'h0000, st.entry[widx]};
         end
      end
      if (bus_i.wr) begin
         if (bus_i.addr == PPCHK_OFS_MASK) begin
            next_st.mask = bus_i.wdata[PPCHK_ST_W-1:0];
         end else if (ewin) begin
            next_st.entry[widx] = bus_i.wdata[15:0] & PPCHK_ENTRY_USED;
         end
      end
      // Set beats the read-clear so a fault in that cycle is kept
      if (req_i.valid & ~admit) begin
         next_st.status[PPCHK_ST_FAULT] = 1'b1;
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st.entry <= {PAGES{PPCHK_ENTRY_RESET}};
         st.status <= '0;
         st.mask <= '0;
         st.rsp <= '0;
         st.fault <= 1'b0;
         st.irq <= 1'b0;
         st.rdata <= 32'h0000_0000;
      end else begin
         st <= next_st;
      end
   end

   assign rsp_o = st.rsp;
   assign fault_o = st.fault;
   assign irq_o = st.irq;
   assign rdata_o = st.rdata;

   // Checks
   // Independent admission model; reusing the datapath terms here would make
   // every verdict property hold by construction
   logic [PPCHK_NUM_DED-1:0] code_hit;
   logic high_hit;
   logic chk_code_ok;
   int type_idx;
   logic chk_type_ok;
   logic chk_admit;
   logic deny_now;
   logic st_rd;

   // One hit term per dedicated code bit
   for (genvar gi = 0; gi < PPCHK_NUM_DED; gi++) begin : g_code_hit
      assign code_hit[gi] = (req_i.code == PPCHK_CODE_W'(gi)) && ent[PPCHK_BIT_CODE0 + gi];
   end
   assign high_hit = (req_i.code >= PPCHK_CODE_W'(PPCHK_NUM_DED)) && ent[PPCHK_BIT_HIGH];
   assign chk_code_ok = req_i.local_cpu ? ent[PPCHK_BIT_LOCAL]
                        : (|code_hit || high_hit);

   // Access bit index: privilege picks the triplet, type the offset inside it
   assign type_idx = (req_i.sup ? PPCHK_BIT_SX : PPCHK_BIT_UX) + (PPCHK_BIT_UR - PPCHK_BIT_UX)
                     - int'(req_i.acc);
   assign chk_type_ok = (req_i.acc inside {PPCHK_ACC_READ, PPCHK_ACC_WRITE, PPCHK_ACC_EXEC})
                        && ent[type_idx[3:0]];
   // Verdict and status helpers shared by the properties
   assign chk_admit = chk_code_ok && chk_type_ok;
   assign deny_now = req_i.valid && !chk_admit;
   assign st_rd = bus_i.rd && (bus_i.addr == PPCHK_OFS_STATUS);

   property p_block_on_deny;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !chk_admit) |=> (rsp_o.block && !rsp_o.grant && fault_o);
   endproperty
   a_block_on_deny: assert property (p_block_on_deny) else $error("deny not blocked");

   property p_grant_on_admit;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && chk_admit) |=> (rsp_o.grant && !fault_o);
   endproperty
   a_grant_on_admit: assert property (p_grant_on_admit) else $error("admit not granted");

   property p_local_bit;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && req_i.local_cpu && !ent[PPCHK_BIT_LOCAL]) |=> rsp_o.block;
   endproperty
   a_local_bit: assert property (p_local_bit) else $error("local bit ignored");

   property p_high_codes;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.local_cpu && req_i.code >= PPCHK_CODE_W'(PPCHK_NUM_DED)
          && !ent[PPCHK_BIT_HIGH])
         |=> rsp_o.block;
   endproperty
   a_high_codes: assert property (p_high_codes) else $error("high code admitted");

   property p_code_zero;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.local_cpu && req_i.code == 0 && !ent[PPCHK_BIT_CODE0])
         |=> rsp_o.block;
   endproperty
   a_code_zero: assert property (p_code_zero) else $error("code zero admitted");

   property p_user_exec;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.sup && req_i.acc == PPCHK_ACC_EXEC && !ent[PPCHK_BIT_UX])
         |=> rsp_o.block;
   endproperty
   a_user_exec: assert property (p_user_exec) else $error("user exec admitted");

   property p_sup_write;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && req_i.sup && req_i.acc == PPCHK_ACC_WRITE && !ent[PPCHK_BIT_SW])
         |=> rsp_o.block;
   endproperty
   a_sup_write: assert property (p_sup_write) else $error("sup write admitted");

   sequence s_fault;
      deny_now;
   endsequence
   property p_irq_follows;
      @(posedge clk_i) disable iff (rst_i)
         (s_fault ##0 st.mask[PPCHK_ST_FAULT]) |=> irq_o;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (rst_i)
         (bus_i.rd && ewin) |=> (rdata_o[7:6] == 2'b00 && rdata_o[31:16] == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   // Verdict shape: one answer per request, none without one
   property p_one_verdict;
      @(posedge clk_i) disable iff (rst_i)
         !(rsp_o.grant && rsp_o.block);
   endproperty
   a_one_verdict: assert property (p_one_verdict) else $error("double verdict");

   property p_quiet_idle;
      @(posedge clk_i) disable iff (rst_i)
         !req_i.valid |=> (!rsp_o.grant && !rsp_o.block && !fault_o);
   endproperty
   a_quiet_idle: assert property (p_quiet_idle) else $error("verdict without request");

   property p_fault_pulse;
      @(posedge clk_i) disable iff (rst_i)
         fault_o == rsp_o.block;
   endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("fault and block differ");

   // Requestor side: set bits must admit once the type also passes
   property p_local_admit;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && req_i.local_cpu && ent[PPCHK_BIT_LOCAL] && chk_type_ok)
         |=> rsp_o.grant;
   endproperty
   a_local_admit: assert property (p_local_admit) else $error("local access refused");

   property p_code_admit;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.local_cpu && |code_hit && chk_type_ok) |=> rsp_o.grant;
   endproperty
   a_code_admit: assert property (p_code_admit) else $error("allowed code refused");

   property p_high_admit;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.local_cpu && high_hit && chk_type_ok) |=> rsp_o.grant;
   endproperty
   a_high_admit: assert property (p_high_admit) else $error("allowed high code refused");

   // Each cleared dedicated bit refuses its own code
   for (genvar gc = 0; gc < PPCHK_NUM_DED; gc++) begin : g_code_chk
      property p_code_bit;
         @(posedge clk_i) disable iff (rst_i)
            (req_i.valid && !req_i.local_cpu && req_i.code == PPCHK_CODE_W'(gc)
             && !ent[PPCHK_BIT_CODE0 + gc]) |=> rsp_o.block;
      endproperty
      a_code_bit: assert property (p_code_bit) else $error("cleared code bit admitted");
   end

   // Access side: privilege picks which cleared bit refuses
   property p_user_read;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.sup && req_i.acc == PPCHK_ACC_READ && !ent[PPCHK_BIT_UR])
         |=> rsp_o.block;
   endproperty
   a_user_read: assert property (p_user_read) else $error("user read admitted");

   property p_user_write;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && !req_i.sup && req_i.acc == PPCHK_ACC_WRITE && !ent[PPCHK_BIT_UW])
         |=> rsp_o.block;
   endproperty
   a_user_write: assert property (p_user_write) else $error("user write admitted");

   property p_sup_exec;
      @(posedge clk_i) disable iff (rst_i)
         (req_i.valid && req_i.sup && req_i.acc == PPCHK_ACC_EXEC && !ent[PPCHK_BIT_SX])
         |=> rsp_o.block;
   endproperty
   a_sup_exec: assert property (p_sup_exec) else $error("sup exec admitted");

   // Status: set wins over the read-clear, then holds until read
   property p_fault_sticky;
      @(posedge clk_i) disable iff (rst_i)
         s_fault |=> st.status[PPCHK_ST_FAULT];
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault not recorded");

   property p_status_clear;
      @(posedge clk_i) disable iff (rst_i)
         (st_rd && !deny_now) |=> (st.status == '0);
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   property p_status_hold;
      @(posedge clk_i) disable iff (rst_i)
         (st.status[PPCHK_ST_FAULT] && !st_rd) |=> st.status[PPCHK_ST_FAULT];
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status lost");

   property p_irq_level;
      @(posedge clk_i) disable iff (rst_i)
         irq_o == |(st.status & st.mask);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

   // Register file: entries change only by a write to their own slot
   property p_entry_write;
      @(posedge clk_i) disable iff (rst_i)
         (bus_i.wr && ewin)
         |=> (st.entry[$past(widx)] == ($past(bus_i.wdata[15:0]) & PPCHK_ENTRY_USED));
   endproperty
   a_entry_write: assert property (p_entry_write) else $error("entry write lost");

   property p_entry_stable;
      @(posedge clk_i) disable iff (rst_i)
         !(bus_i.wr && ewin) |=> $stable(st.entry);
   endproperty
   a_entry_stable: assert property (p_entry_stable) else $error("entry changed unwritten");

   property p_rdata_idle;
      @(posedge clk_i) disable iff (rst_i)
         !bus_i.rd |=> (rdata_o == 32'h0000_0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule

// file: hdl/ppchk_pkg.sv
// Package for the page permission checker: register map, entry fields, types.
// Assumes a single system clock and a plain strobe register port.
package ppchk_pkg;
   // Geometry
   localparam int PPCHK_ADDR_W = 32;
   localparam int PPCHK_CODE_W = 4;
   localparam int PPCHK_PAGE_SHIFT = 12;
   localparam int PPCHK_PAGES = 16;
   localparam int PPCHK_PAGE_W = 4;
   localparam int PPCHK_REG_AW = 8;
   localparam int PPCHK_NUM_DED = 6;
   // Register byte offsets
   localparam logic [7:0] PPCHK_OFS_STATUS = 8'h00;
   localparam logic [7:0] PPCHK_OFS_MASK = 8'h04;
   localparam logic [7:0] PPCHK_OFS_ENTRY0 = 8'h40;
   localparam logic [7:0] PPCHK_OFS_ENTRY_LAST = 8'h7C;
   // Entry field positions
   localparam int PPCHK_BIT_CODE0 = 10;
   localparam int PPCHK_BIT_HIGH = 9;
   localparam int PPCHK_BIT_LOCAL = 8;
   localparam int PPCHK_BIT_SR = 5;
   localparam int PPCHK_BIT_SW = 4;
   localparam int PPCHK_BIT_SX = 3;
   localparam int PPCHK_BIT_UR = 2;
   localparam int PPCHK_BIT_UW = 1;
   localparam int PPCHK_BIT_UX = 0;
   localparam logic [15:0] PPCHK_ENTRY_USED = 16'hFF3F;
   localparam logic [15:0] PPCHK_ENTRY_RESET = 16'hFF3F;
   // Status bits
   localparam int PPCHK_ST_FAULT = 0;
   localparam int PPCHK_ST_W = 1;

   typedef enum logic [1:0] {
      PPCHK_ACC_READ = 2'b00,
      PPCHK_ACC_WRITE = 2'b01,
      PPCHK_ACC_EXEC = 2'b10
   } ppchk_acc_t;

   typedef struct packed {
      logic valid;
      logic [PPCHK_ADDR_W-1:0] addr;
      logic [PPCHK_CODE_W-1:0] code;
      logic sup;
      logic local_cpu;
      ppchk_acc_t acc;
   } ppchk_req_t;

   typedef struct packed {
      logic grant;
      logic block;
   } ppchk_rsp_t;

   typedef struct packed {
      logic [PPCHK_REG_AW-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ppchk_bus_t;
endpackage

// file: verif/ppchk_req_model.sv
// Requestor model: CPU and DMA side of the checker's request port.
// Assumes one request per call, raised right after a rising edge.
`timescale 1ns/10ps
module ppchk_req_model (
   // Clock
   input wire logic clk_i,
   // Request to checker
   output ppchk_pkg::ppchk_req_t req_o
);
   import ppchk_pkg::*;
   logic [PPCHK_CODE_W-1:0] dma_code;
   logic dma_sup;
   // Quiet port from time zero
   initial begin
      req_o = '0;
      dma_code = '0;
      dma_sup = 1'b0;
   end
   // One-cycle request, fields held up to the taking edge
   task automatic issue(input logic [31:0] a, input logic [3:0] c, input logic s,
                        input logic l, input ppchk_acc_t t);
      @(posedge clk_i);
      req_o <= '{1'b1, a, c, s, l, t};
      @(posedge clk_i);
      req_o.valid <= 1'b0;
   endtask
   // Starter's code and privilege frozen at start, later mode changes ignored
   task automatic dma_start(input logic [3:0] c, input logic s);
      dma_code = c;
      dma_sup = s;
   endtask
   task automatic dma_access(input logic [31:0] a, input ppchk_acc_t t);
      issue(a, dma_code, dma_sup, 1'b0, t);
   endtask
endmodule

// file: verif/tb_page_permission_checker.sv
// Testbench for the page permission checker: register and request checks.
// Assumes the requestor model and a 25 MHz system clock.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_page_permission_checker;
   import ppchk_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   ppchk_req_t req;
   ppchk_rsp_t rsp;
   ppchk_bus_t bus = '0;
   logic [31:0] rdata;
   logic fault;
   logic irq;
   int error_cnt = 0;
   int total_checks = 0;
   int k;
   int c;
   int s;
   int t;
   logic g;
   // 40 ns clock
   always #20 clk_i = ~clk_i;
   ppchk_req_model m (.clk_i(clk_i), .req_o(req));
   ppchk_top DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp), .bus_i(bus),
                  .rdata_o(rdata), .fault_o(fault), .irq_o(irq));
   // Register port cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   // Verdict is a one-cycle pulse after the taking edge
   task automatic chk_req(input logic [31:0] a, input int cd, input logic s, input logic l,
                          input ppchk_acc_t t, input logic e);
      m.issue(a, cd[3:0], s, l, t);
      #1 `CHK({rsp.grant, rsp.block, fault}, {e, !e, !e})
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(PPCHK_OFS_ENTRY0, 32'h0000FF3F);
      rd(PPCHK_OFS_MASK, 32'h0);
      rd(8'h20, 32'h0);
      wr(8'h44, 32'hFFFFFFFF);
      rd(8'h44, 32'h0000FF3F);
      $display("test reset_layout done");
      // One admission bit at a time; last pass leaves only the local bit
      for (k = 0; k < 8; k++) begin
         wr(8'h44, 32'h3F | (k < 6 ? 32'h400 << k : (k == 6 ? 32'h200 : 32'h100)));
         for (c = 0; c < 9; c++) begin
            g = (c < 6) ? (c == k) : (k == 6);
            chk_req(32'h1000, (c == 8) ? 15 : c, 1'b1, 1'b0, PPCHK_ACC_READ, g);
         end
         chk_req(32'h1FFC, 0, 1'b1, 1'b1, PPCHK_ACC_READ, k == 7);
      end
      chk_req(32'h2000, 7, 1'b0, 1'b0, PPCHK_ACC_EXEC, 1'b1);
      $display("test requestor_codes done");
      // One access bit at a time against every privilege and type
      for (k = 0; k < 6; k++) begin
         wr(8'h4C, 32'hFF00 | (32'h1 << k));
         for (s = 0; s < 2; s++)
            for (t = 0; t < 3; t++)
               chk_req(32'h3000, 2, s[0], 1'b0, ppchk_acc_t'(t), k == (s ? 5 - t : 2 - t));
      end
      $display("test access_types done");
      // Sticky status, read clear, ignored write, masked level output
      rd(PPCHK_OFS_STATUS, 32'h1);
      wr(PPCHK_OFS_STATUS, 32'h1);
      rd(PPCHK_OFS_STATUS, 32'h0);
      wr(PPCHK_OFS_MASK, 32'h1);
      rd(PPCHK_OFS_MASK, 32'h1);
      `CHK(irq, 1'b0)
      m.dma_start(4'h2, 1'b0);
      m.dma_access(32'h3000, PPCHK_ACC_READ);
      #1 `CHK({rsp.grant, rsp.block, fault}, 3'b011)
      @(posedge clk_i);
      #1 `CHK(irq, 1'b1)
      rd(PPCHK_OFS_STATUS, 32'h1);
      @(posedge clk_i);
      #1 `CHK(irq, 1'b0)
      $display("test fault_irq done");
      give_verdict();
   end
endmodule
